// file: fcfl_classify.sv
// Classifier for one single-precision stack entry.
// Assumes the caller supplies the entry's value and its empty tag.
`timescale 1ns/1ps
module fcfl_classify
  import fcfl_pkg::*;
(
  input wire logic [31:0] value,
  input wire logic empty,
  output fcfl_class_t cls,
  output logic is_nan,
  output logic is_snan
);

  logic exp_ones;
  logic exp_zero;
  logic frac_zero;

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  assign exp_ones = &value[30:23];
  assign exp_zero = ~|value[30:23];
  assign frac_zero = ~|value[22:0];
  // Empty slot is not a NaN; callers treat it separately
  assign is_nan = !empty && exp_ones && !frac_zero;
  // Quiet bit low marks a signaling NaN
  assign is_snan = is_nan && !value[22];

  // Single precision has no unsupported encodings
  always_comb
  begin
    if (empty)
      cls = FCFL_CLS_EMPTY;
    else if (is_nan)
      cls = FCFL_CLS_NAN;
    else if (exp_ones)
      cls = FCFL_CLS_INFINITY;
    else if (exp_zero && frac_zero)
      cls = FCFL_CLS_ZERO;
    else if (exp_zero)
      cls = FCFL_CLS_DENORMAL;
    else
      cls = FCFL_CLS_NORMAL;
  end

endmodule : fcfl_classify

// file: fcfl_pkg.sv
// Constants for the floating-point compare and classify flag block.
// Assumes an AXI4-Lite master with 32-bit data and byte addressing.
package fcfl_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] FCFL_OFF_COMMAND = 8'h00;
  localparam logic [7:0] FCFL_OFF_PUSH = 8'h04;
  localparam logic [7:0] FCFL_OFF_STATUS_WORD = 8'h08;
  localparam logic [7:0] FCFL_OFF_INT_FLAGS = 8'h0C;
  localparam logic [7:0] FCFL_OFF_ACCUM = 8'h10;
  localparam logic [7:0] FCFL_OFF_FEATURE = 8'h14;
  localparam logic [7:0] FCFL_OFF_IRQ_STATUS = 8'h18;
  localparam logic [7:0] FCFL_OFF_IRQ_CLEAR = 8'h1C;
  localparam logic [7:0] FCFL_OFF_IRQ_ENABLE = 8'h20;
  localparam logic [7:0] FCFL_OFF_TOP_VALUE = 8'h24;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FCFL_SW_INVALID = 0;
  localparam int FCFL_SW_CC0 = 8;
  localparam int FCFL_SW_CC1 = 9;
  localparam int FCFL_SW_CC2 = 10;
  localparam int FCFL_SW_TOP_LO = 11;
  localparam int FCFL_SW_CC3 = 14;
  localparam int FCFL_IF_CARRY = 0;
  localparam int FCFL_IF_PARITY = 2;
  localparam int FCFL_IF_ZERO = 6;
  localparam int FCFL_IRQ_INVALID = 0;
  localparam int FCFL_IRQ_DONE = 1;
  localparam int FCFL_IRQ_BITS = 2;
  localparam int FCFL_CMD_IDX_LO = 4;

  // ----------------------------------------------------------------
  // Reset values and sizes
  // ----------------------------------------------------------------
  localparam int FCFL_PTR_W = 3;
  localparam logic [FCFL_PTR_W-1:0] FCFL_PTR_RESET = 3'h0;
  localparam logic [FCFL_IRQ_BITS-1:0] FCFL_IRQ_RESET = 2'h0;
  localparam logic [31:0] FCFL_WORD_RESET = 32'h00000000;
  localparam logic [1:0] FCFL_RESP_OKAY = 2'h0;
  localparam logic [1:0] FCFL_RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Commands written to the command register
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    FCFL_CMD_NOP = 4'h0,
    FCFL_CMD_CMP_INT = 4'h1,
    FCFL_CMD_CMP_INT_POP = 4'h2,
    FCFL_CMD_UCMP_INT = 4'h3,
    FCFL_CMD_UCMP_INT_POP = 4'h4,
    FCFL_CMD_EXAMINE = 4'h5,
    FCFL_CMD_STORE_SW = 4'h6,
    FCFL_CMD_CMP_CC = 4'h7,
    FCFL_CMD_POP = 4'h8
  } fcfl_cmd_t;

  // Examine classes as {cc3, cc2, cc0}
  typedef enum logic [2:0] {
    FCFL_CLS_UNSUPPORTED = 3'h0,
    FCFL_CLS_NAN = 3'h1,
    FCFL_CLS_NORMAL = 3'h2,
    FCFL_CLS_INFINITY = 3'h3,
    FCFL_CLS_ZERO = 3'h4,
    FCFL_CLS_EMPTY = 3'h5,
    FCFL_CLS_DENORMAL = 3'h6
  } fcfl_class_t;

endpackage : fcfl_pkg

// file: fcfl_top.sv
// Floating-point compare and classify flag block with AXI4-Lite registers.
// Assumes one clock MCLK, async active-low RSTN, single-outstanding master.
// Operation
// - Int-flag compare sets zero, parity, carry flags
// - Unordered variant quiet on quiet NaNs
// - Popping forms pop once after update
// - Ordinary compare raises invalid when unordered
// - Examine classifies stack top into condition codes
// - Examine writes sign into condition code one
// - Branching needs status word copied to accumulator
// - Condition codes at 0100H, 0400H, 4000H
// - Test against 0400H isolates unordered result
// - Other operations overwrite codes; store promptly
// - Feature query reports compare support
// - Code compare sets codes three, two, zero
`timescale 1ns/1ps
module fcfl_top
  import fcfl_pkg::*;
#(
  parameter logic COMPARE_SUPPORTED = 1'b1,
  parameter int DEPTH = 8
)
(
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic ZERO_FLAG,
  output logic PARITY_FLAG,
  output logic CARRY_FLAG,
  output logic IRQ
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic aw_held;
  logic w_held;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic do_write;
  logic [31:0] strb_mask;
  logic [31:0] wr_masked;
  logic wr_mapped;
  logic rd_mapped;
  logic [31:0] rd_word;
  logic [31:0] stack_val [DEPTH];
  logic [DEPTH-1:0] tag;
  logic [FCFL_PTR_W-1:0] ptr;
  logic [FCFL_PTR_W-1:0] oth_ptr;
  logic cc0;
  logic cc1;
  logic cc2;
  logic cc3;
  logic invalid_sticky;
  logic [31:0] accum;
  logic [FCFL_IRQ_BITS-1:0] irq_status;
  logic [FCFL_IRQ_BITS-1:0] irq_enable;
  logic [FCFL_IRQ_BITS-1:0] irq_set;
  logic [FCFL_IRQ_BITS-1:0] irq_clear;
  logic [15:0] status_word;
  logic cmd_go;
  logic push_go;
  fcfl_cmd_t cmd;
  logic [31:0] a_val;
  logic [31:0] b_val;
  logic a_empty;
  logic b_empty;
  fcfl_class_t a_cls;
  fcfl_class_t b_cls;
  logic a_nan;
  logic b_nan;
  logic a_snan;
  logic b_snan;
  logic unordered;
  logic rel_eq;
  logic rel_lt;
  logic is_int_cmp;
  logic is_unord_var;
  logic is_pop;
  logic raise_invalid;
  logic push_fault;

  // ----------------------------------------------------------------
  // Write channel: address and data taken in either order
  // ----------------------------------------------------------------
  assign do_write = aw_held && w_held && !S_AXI_BVALID;

  // Ready stays low from take until response, one write in flight
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= FCFL_WORD_RESET;
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY <= 1'b1;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= FCFL_RESP_OKAY;
    end
    else
    begin
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_held <= 1'b1;
        wr_addr <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_held <= 1'b1;
        wr_data <= wr_masked;
        S_AXI_WREADY <= 1'b0;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_mapped ? FCFL_RESP_OKAY : FCFL_RESP_SLVERR;
      end
      else if (S_AXI_BVALID && S_AXI_BREADY)
      begin
        S_AXI_BVALID <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY <= 1'b1;
      end
    end
  end

  // Byte lanes not strobed are written as zero
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      strb_mask[i*8 +: 8] = {8{S_AXI_WSTRB[i]}};
  end
  assign wr_masked = S_AXI_WDATA & strb_mask;

  // Only command, push, clear and enable accept writes
  assign wr_mapped = (wr_addr == FCFL_OFF_COMMAND) || (wr_addr == FCFL_OFF_PUSH)
    || (wr_addr == FCFL_OFF_IRQ_CLEAR) || (wr_addr == FCFL_OFF_IRQ_ENABLE);
  assign cmd_go = do_write && (wr_addr == FCFL_OFF_COMMAND);
  assign push_go = do_write && (wr_addr == FCFL_OFF_PUSH);
  assign cmd = fcfl_cmd_t'(wr_data[3:0]);

  // ----------------------------------------------------------------
  // Operands: stack top and the indexed entry
  // ----------------------------------------------------------------
  assign oth_ptr = ptr + wr_data[FCFL_CMD_IDX_LO +: FCFL_PTR_W];
  assign a_val = stack_val[ptr];
  assign b_val = stack_val[oth_ptr];
  assign a_empty = !tag[ptr];
  assign b_empty = !tag[oth_ptr];

  fcfl_classify u_cls_top (
    .value(a_val),
    .empty(a_empty),
    .cls(a_cls),
    .is_nan(a_nan),
    .is_snan(a_snan)
  );

  fcfl_classify u_cls_other (
    .value(b_val),
    .empty(b_empty),
    .cls(b_cls),
    .is_nan(b_nan),
    .is_snan(b_snan)
  );

  // ----------------------------------------------------------------
  // Relation; empty entries count as unordered operands
  // ----------------------------------------------------------------
  assign unordered = a_nan || b_nan || a_empty || b_empty;

  // Both zeros are equal whatever their signs
  always_comb
  begin
    rel_eq = 1'b0;
    rel_lt = 1'b0;
    if ((a_val[30:0] == 31'h00000000) && (b_val[30:0] == 31'h00000000))
      rel_eq = 1'b1;
    else if (a_val[31] != b_val[31])
      rel_lt = a_val[31];
    else if (a_val[30:0] == b_val[30:0])
      rel_eq = 1'b1;
    else
      rel_lt = a_val[31] ^ (a_val[30:0] < b_val[30:0]);
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  assign is_int_cmp = (cmd == FCFL_CMD_CMP_INT) || (cmd == FCFL_CMD_CMP_INT_POP)
    || (cmd == FCFL_CMD_UCMP_INT) || (cmd == FCFL_CMD_UCMP_INT_POP);
  assign is_unord_var = (cmd == FCFL_CMD_UCMP_INT) || (cmd == FCFL_CMD_UCMP_INT_POP);
  assign is_pop = (cmd == FCFL_CMD_CMP_INT_POP) || (cmd == FCFL_CMD_UCMP_INT_POP)
    || (cmd == FCFL_CMD_POP);
  // Pushing onto an occupied slot is a stack overflow
  assign push_fault = push_go && tag[ptr - 3'h1];

  // Invalid operation decision per compare flavour
  always_comb
  begin
    raise_invalid = push_fault;
    if (cmd_go && (is_int_cmp || (cmd == FCFL_CMD_CMP_CC)))
    begin
      if (is_unord_var)
        raise_invalid = a_snan || b_snan || a_empty || b_empty;
      else
        raise_invalid = unordered;
    end
  end

  // ----------------------------------------------------------------
  // Register stack; pop happens in the same edge as the flag update
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      ptr <= FCFL_PTR_RESET;
      tag <= '0;
      for (int i = 0; i < DEPTH; i++)
        stack_val[i] <= FCFL_WORD_RESET;
    end
    else if (push_go && !push_fault)
    begin
      ptr <= ptr - 3'h1;
      tag[ptr - 3'h1] <= 1'b1;
      stack_val[ptr - 3'h1] <= wr_data;
    end
    else if (cmd_go && is_pop)
    begin
      tag[ptr] <= 1'b0;
      ptr <= ptr + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // Integer status flags
  // ----------------------------------------------------------------
  // zero, parity, carry
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      ZERO_FLAG <= 1'b0;
      PARITY_FLAG <= 1'b0;
      CARRY_FLAG <= 1'b0;
    end
    else if (cmd_go && is_int_cmp)
    begin
      ZERO_FLAG <= unordered || rel_eq;
      PARITY_FLAG <= unordered;
      CARRY_FLAG <= unordered || rel_lt;
    end
  end

  // ----------------------------------------------------------------
  // Condition codes
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      cc0 <= 1'b0;
      cc1 <= 1'b0;
      cc2 <= 1'b0;
      cc3 <= 1'b0;
    end
    else if (cmd_go)
    begin
      case (cmd)
        FCFL_CMD_CMP_CC:
        begin
          cc3 <= unordered || rel_eq;
          cc2 <= unordered;
          cc0 <= unordered || rel_lt;
          cc1 <= 1'b0;
        end
        FCFL_CMD_EXAMINE:
        begin
          cc3 <= a_cls[2];
          cc2 <= a_cls[1];
          cc0 <= a_cls[0];
          cc1 <= a_val[31];
        end
        default:
        begin
          cc0 <= cc0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Status word and its snapshot
  // ----------------------------------------------------------------
  // fixed bit positions
  always_comb
  begin
    status_word = 16'h0000;
    status_word[FCFL_SW_INVALID] = invalid_sticky;
    status_word[FCFL_SW_CC0] = cc0;
    status_word[FCFL_SW_CC1] = cc1;
    status_word[FCFL_SW_CC2] = cc2;
    status_word[FCFL_SW_TOP_LO +: FCFL_PTR_W] = ptr;
    status_word[FCFL_SW_CC3] = cc3;
  end

  // Invalid stays set until a later invalid-free run is irrelevant
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
      invalid_sticky <= 1'b0;
    else if (raise_invalid)
      invalid_sticky <= 1'b1;
  end

  // copy kept past later updates
  // Snapshot shields codes from later examine or compare
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
      accum <= FCFL_WORD_RESET;
    else if (cmd_go && (cmd == FCFL_CMD_STORE_SW))
      accum <= {16'h0000, status_word};
  end

  // ----------------------------------------------------------------
  // Interrupts: sticky status, write-one clear, enable mask
  // ----------------------------------------------------------------
  always_comb
  begin
    irq_set = FCFL_IRQ_RESET;
    irq_set[FCFL_IRQ_INVALID] = raise_invalid;
    irq_set[FCFL_IRQ_DONE] = cmd_go && (cmd != FCFL_CMD_NOP);
    irq_clear = FCFL_IRQ_RESET;
    if (do_write && (wr_addr == FCFL_OFF_IRQ_CLEAR))
      irq_clear = wr_data[FCFL_IRQ_BITS-1:0];
  end

  // Set beats clear in the same cycle so no event is lost
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
      irq_status <= FCFL_IRQ_RESET;
    else
      irq_status <= (irq_status & ~irq_clear) | irq_set;
  end

  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
      irq_enable <= FCFL_IRQ_RESET;
    else if (do_write && (wr_addr == FCFL_OFF_IRQ_ENABLE))
      irq_enable <= wr_data[FCFL_IRQ_BITS-1:0];
  end

  // Registered, so it trails the status bit by one cycle
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
      IRQ <= 1'b0;
    else
      IRQ <= |(irq_status & irq_enable);
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_word = FCFL_WORD_RESET;
    rd_mapped = 1'b1;
    case (S_AXI_ARADDR)
      FCFL_OFF_STATUS_WORD: rd_word = {16'h0000, status_word};
      FCFL_OFF_INT_FLAGS:
      begin
        rd_word[FCFL_IF_ZERO] = ZERO_FLAG;
        rd_word[FCFL_IF_PARITY] = PARITY_FLAG;
        rd_word[FCFL_IF_CARRY] = CARRY_FLAG;
      end
      FCFL_OFF_ACCUM: rd_word = accum;
      FCFL_OFF_FEATURE: rd_word[0] = COMPARE_SUPPORTED;
      FCFL_OFF_IRQ_STATUS: rd_word[FCFL_IRQ_BITS-1:0] = irq_status;
      FCFL_OFF_IRQ_ENABLE: rd_word[FCFL_IRQ_BITS-1:0] = irq_enable;
      FCFL_OFF_TOP_VALUE: rd_word = a_val;
      // Write-only registers read as zero
      FCFL_OFF_COMMAND: rd_word = FCFL_WORD_RESET;
      FCFL_OFF_PUSH: rd_word = FCFL_WORD_RESET;
      FCFL_OFF_IRQ_CLEAR: rd_word = FCFL_WORD_RESET;
      default: rd_mapped = 1'b0;
    endcase
  end

  // Data captured at address take, answered the next cycle
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= FCFL_WORD_RESET;
      S_AXI_RRESP <= FCFL_RESP_OKAY;
    end
    else if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_word;
      S_AXI_RRESP <= rd_mapped ? FCFL_RESP_OKAY : FCFL_RESP_SLVERR;
    end
    else if (S_AXI_RVALID && S_AXI_RREADY)
    begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

endmodule : fcfl_top

// file: fcfl_top_bench.sv
// Self-checking bench for the compare and classify flag block.
// Assumes the register map of fcfl_pkg; the bench is the bus master.
`timescale 1ns/1ps
`define CHK(g, e, m) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH t=%0t %s", $time, m); end end
module fcfl_top_bench
  import fcfl_pkg::*;
;
  typedef struct packed {logic [3:0] c; logic [31:0] a; logic [31:0] b; logic [2:0] r; logic i;} fcfl_row_t;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, zf, pf, cf, irq;
  logic [1:0] bresp, rresp;
  logic [15:0] sw;
  fcfl_row_t rw;
  fcfl_row_t rows [16];
  int error_cnt = 0;
  int checks_done = 0;

  // ----------------------------------------------------------------
  // Clock, device and bus tasks
  // ----------------------------------------------------------------
  always #2.5 mclk = ~mclk;

  fcfl_top i_dut (.MCLK(mclk), .RSTN(rstn), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .ZERO_FLAG(zf),
    .PARITY_FLAG(pf), .CARRY_FLAG(cf), .IRQ(irq));

  task automatic rst_dut();
    rstn <= 1'b0;
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
  endtask : rst_dut

  // Ready is looked at on the falling edge, so the take edge is never raced
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    tb = 1'b0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 50 && !tb; n++)
    begin
      @(negedge mclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      if (tb) `CHK(bresp, er, "write response")
      @(posedge mclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      bready <= !tb;
    end
    `CHK(tb, 1'b1, "write never answered")
  endtask : axw

  task automatic axr(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    logic ta, tb;
    tb = 1'b0;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 50 && !tb; n++)
    begin
      @(negedge mclk);
      ta = arvalid && arready;
      tb = rvalid && rready;
      d = rdata;
      if (tb) `CHK(rresp, er, "read response")
      @(posedge mclk);
      if (ta) arvalid <= 1'b0;
      rready <= !tb;
    end
    `CHK(tb, 1'b1, "read never answered")
  endtask : axr

  task automatic cmd(input logic [3:0] c, input logic [2:0] i);
    axw(FCFL_OFF_COMMAND, {25'h0, i, c}, FCFL_RESP_OKAY);
  endtask : cmd

  task automatic push(input logic [31:0] v);
    axw(FCFL_OFF_PUSH, v, FCFL_RESP_OKAY);
  endtask : push

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out

  // ----------------------------------------------------------------
  // Watchdog, well beyond the several hundred cycles the run needs
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    close_out();
  end

  // ----------------------------------------------------------------
  // Table of compares and examines, then hand-written cases
  // ----------------------------------------------------------------
  initial
  begin
    rows = '{'{4'h1, 32'h40000000, 32'h3F800000, 3'h0, 1'b0}, '{4'h2, 32'h3F800000, 32'h40000000, 3'h1, 1'b0},
      '{4'h1, 32'h00000000, 32'h80000000, 3'h4, 1'b0}, '{4'h1, 32'h7FC00000, 32'h3F800000, 3'h7, 1'b1},
      '{4'h3, 32'h7FC00000, 32'h3F800000, 3'h7, 1'b0}, '{4'h4, 32'h3F800000, 32'h7F800001, 3'h7, 1'b1},
      '{4'h3, 32'hBF800000, 32'h3F800000, 3'h1, 1'b0}, '{4'h7, 32'h40000000, 32'h3F800000, 3'h0, 1'b0},
      '{4'h7, 32'h3F800000, 32'h40000000, 3'h1, 1'b0}, '{4'h7, 32'h3F800000, 32'h3F800000, 3'h4, 1'b0},
      '{4'h7, 32'h7FC00000, 32'h3F800000, 3'h7, 1'b1}, '{4'h5, 32'h80000000, 32'h3F800000, FCFL_CLS_ZERO, 1'b0},
      '{4'h5, 32'h00000001, 32'h3F800000, FCFL_CLS_DENORMAL, 1'b0},
      '{4'h5, 32'hBF800000, 32'h3F800000, FCFL_CLS_NORMAL, 1'b0},
      '{4'h5, 32'h7F800000, 32'h3F800000, FCFL_CLS_INFINITY, 1'b0},
      '{4'h5, 32'h7FC00000, 32'h3F800000, FCFL_CLS_NAN, 1'b0}};
    // Fresh stack per row, so pointer and sticky invalid are known
    for (int k = 0; k < 16; k++)
    begin
      rw = rows[k];
      rst_dut();
      push(rw.b);
      push(rw.a);
      cmd(rw.c, 3'h1);
      cmd(FCFL_CMD_STORE_SW, 3'h0);
      axr(FCFL_OFF_ACCUM, FCFL_RESP_OKAY, rd);
      sw = 16'h0000;
      sw[FCFL_SW_INVALID] = rw.i;
      sw[FCFL_SW_TOP_LO +: 3] = (rw.c == 4'h2 || rw.c == 4'h4) ? 3'h7 : 3'h6;
      if (rw.c >= 4'h5)
        {sw[FCFL_SW_CC3], sw[FCFL_SW_CC2], sw[FCFL_SW_CC0]} = rw.r;
      if (rw.c == 4'h5)
        sw[FCFL_SW_CC1] = rw.a[31];
      `CHK(rd[15:0], sw, "stored status word")
      `CHK({zf, pf, cf}, (rw.c < 4'h5) ? rw.r : 3'h0, "integer flags")
      if (rw.c == 4'h7)
        `CHK({(rd[15:0] & 16'h4500) == 16'h0, (rd[15:0] & 16'h0100) != 16'h0, (rd[15:0] & 16'h4000) != 16'h0,
          (rd[15:0] & 16'h0400) != 16'h0}, {rw.r == 3'h0, rw.r[0], rw.r[2], rw.r[1]}, "mask tests")
      $display("row %0d done", k);
    end
    // Reset values, feature bit, refused accesses
    rst_dut();
    `CHK({zf, pf, cf, irq}, 4'h0, "reset outputs")
    axr(FCFL_OFF_STATUS_WORD, FCFL_RESP_OKAY, rd);
    `CHK(rd, FCFL_WORD_RESET, "reset status word")
    axr(FCFL_OFF_FEATURE, FCFL_RESP_OKAY, rd);
    `CHK(rd[0], 1'b1, "feature bit")
    axr(8'h3C, FCFL_RESP_SLVERR, rd);
    `CHK(rd, 32'h0, "unmapped read data")
    axw(FCFL_OFF_STATUS_WORD, 32'hFFFF, FCFL_RESP_SLVERR);
    $display("reset test done");
    // Empty stack: examine, then unordered compare still faults
    cmd(FCFL_CMD_EXAMINE, 3'h0);
    cmd(FCFL_CMD_UCMP_INT, 3'h1);
    `CHK({zf, pf, cf}, 3'h7, "empty compare flags")
    axr(FCFL_OFF_STATUS_WORD, FCFL_RESP_OKAY, rd);
    sw = 16'h0001;
    {sw[FCFL_SW_CC3], sw[FCFL_SW_CC2], sw[FCFL_SW_CC0]} = FCFL_CLS_EMPTY;
    `CHK(rd[15:0] & 16'hFDFF, sw, "empty")
    // Stored copy survives a later code update
    rst_dut();
    push(32'h40000000);
    push(32'h3F800000);
    cmd(FCFL_CMD_CMP_CC, 3'h1);
    cmd(FCFL_CMD_STORE_SW, 3'h0);
    cmd(FCFL_CMD_EXAMINE, 3'h0);
    axr(FCFL_OFF_ACCUM, FCFL_RESP_OKAY, rd);
    `CHK(rd[15:0], 16'h3100, "kept copy")
    axr(FCFL_OFF_STATUS_WORD, FCFL_RESP_OKAY, rd);
    `CHK(rd[15:0], 16'h3400, "overwritten codes")
    cmd(FCFL_CMD_POP, 3'h0);
    axr(FCFL_OFF_STATUS_WORD, FCFL_RESP_OKAY, rd);
    `CHK(rd[15:0], 16'h3C00, "plain pop")
    $display("store test done");
    // Interrupt raised, cleared, then masked
    axw(FCFL_OFF_IRQ_ENABLE, 32'h2, FCFL_RESP_OKAY);
    cmd(FCFL_CMD_STORE_SW, 3'h0);
    repeat (2) @(posedge mclk);
    `CHK(irq, 1'b1, "irq raised")
    axw(FCFL_OFF_IRQ_CLEAR, 32'h2, FCFL_RESP_OKAY);
    repeat (2) @(posedge mclk);
    `CHK(irq, 1'b0, "irq cleared")
    axw(FCFL_OFF_IRQ_ENABLE, 32'h0, FCFL_RESP_OKAY);
    cmd(FCFL_CMD_STORE_SW, 3'h0);
    repeat (2) @(posedge mclk);
    `CHK(irq, 1'b0, "irq masked")
    axr(FCFL_OFF_IRQ_STATUS, FCFL_RESP_OKAY, rd);
    `CHK(rd[1:0], 2'h2, "done status")
    $display("irq test done");
    close_out();
  end
endmodule : fcfl_top_bench

// file: fcfl_top_sva.sv
// Checker for the compare and classify flag block, bound to its top ports.
// Assumes one clock MCLK and the asynchronous active-low RSTN.
`timescale 1ns/1ps
module fcfl_top_sva
  import fcfl_pkg::*;
(
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic ZERO_FLAG,
  input wire logic PARITY_FLAG,
  input wire logic CARRY_FLAG,
  input wire logic IRQ
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RSTN);

  // Only four flag patterns exist; parity alone marks unordered
  a_flags_legal: assert property (
    PARITY_FLAG ? (ZERO_FLAG && CARRY_FLAG) : !(ZERO_FLAG && CARRY_FLAG))
    else $error("illegal integer flag pattern");
  // Flags move only with a write taking effect
  a_flags_on_write: assert property (
    !$stable({ZERO_FLAG, PARITY_FLAG, CARRY_FLAG}) |-> $rose(S_AXI_BVALID))
    else $error("flags changed without a command write");
  a_bresp_hold: assert property (
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped before taken");
  a_rdata_hold: assert property (
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped before taken");
  a_write_answer: assert property (
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
    |=> !S_AXI_AWREADY && !S_AXI_WREADY ##1 S_AXI_BVALID)
    else $error("write not answered two cycles after take");
  a_read_answer: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
    else $error("read not answered one cycle after take");
  a_ready_return: assert property (
    $fell(S_AXI_BVALID) |-> ##[0:1] (S_AXI_AWREADY && S_AXI_WREADY))
    else $error("write channels not ready again");
  // Interrupt line follows status and enable, both written over the bus
  a_irq_cause: assert property (
    !$stable(IRQ) |-> $past(S_AXI_BVALID))
    else $error("interrupt moved without a write");

  c_unordered: cover property (ZERO_FLAG && PARITY_FLAG && CARRY_FLAG);
  c_irq_rise: cover property ($rose(IRQ));
  c_slverr: cover property (S_AXI_BVALID && S_AXI_BRESP == FCFL_RESP_SLVERR);
endmodule : fcfl_top_sva

bind fcfl_top fcfl_top_sva i_sva (.MCLK(MCLK), .RSTN(RSTN), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .ZERO_FLAG(ZERO_FLAG),
  .PARITY_FLAG(PARITY_FLAG), .CARRY_FLAG(CARRY_FLAG), .IRQ(IRQ));
